// ==== design/ret_event_timer.v ====
/*
 Event driven 20-bit countdown timer with its register slave.
 Assumes event inputs are one-cycle pulses from logic on the same clock
 and a bus master that never issues read and write strobes together.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "ret_defines.vh"

// Behaviour
// - Stop when reception first bit arrives
// - Stop when transmission begins
// - Stop on external field on, off
// - Stop on own field on, off
// - Stop on receive path activity
// - Start when reception first bit arrives
// - Start when reception ends
// - Start on transmission begin, end
// - Start on external field on, off
// - Start on own field on, off
// - Immediate start bit starts timer
// - Single run ignores restarts while running
// - Rate code halves from 6.78 MHz
// - Clock source picks undivided or prescaled
// - No auto reload: stop, hold zero
// - Auto reload: reload and continue
// - Enable bit gates all operation
// - 20-bit reload preset, upper bits zero
module ret_event_timer #(
	parameter CNT_W = 20
) (
	clock,
	reset,
	bus_addr,
	bus_wdata,
	bus_write,
	bus_read,
	bus_rdata,
	rx_begin_evt,
	rx_end_evt,
	tx_begin_evt,
	tx_end_evt,
	ext_field_on_evt,
	ext_field_off_evt,
	own_field_on_evt,
	own_field_off_evt,
	rx_activity_evt,
	timer_expired,
	timer_running,
	timer_count
);
	input wire clock;
	input wire reset;
	input wire [`RET_ADDR_W-1:0] bus_addr;
	input wire [31:0] bus_wdata;
	input wire bus_write;
	input wire bus_read;
	output wire [31:0] bus_rdata;
	input wire rx_begin_evt;
	input wire rx_end_evt;
	input wire tx_begin_evt;
	input wire tx_end_evt;
	input wire ext_field_on_evt;
	input wire ext_field_off_evt;
	input wire own_field_on_evt;
	input wire own_field_off_evt;
	input wire rx_activity_evt;
	output wire timer_expired;
	output wire timer_running;
	output wire [CNT_W-1:0] timer_count;

	reg [31:0] config_ff;
	reg [CNT_W-1:0] reload_ff;
	reg [CNT_W-1:0] count_ff;
	reg [CNT_W-1:0] nxt_count;
	reg running_ff;
	reg nxt_running;
	reg expired_ff;
	reg nxt_expired;
	reg imm_start_ff;
	reg [`RET_PRESCALE_W-1:0] prescale_ff;
	reg [`RET_PRESCALE_W-1:0] nxt_prescale;
	reg [31:0] rdata_ff;
	reg [31:0] nxt_rdata;

	wire cfg_sel;
	wire reload_sel;
	wire status_sel;
	wire stop_hit;
	wire start_hit;
	wire tick;
	wire enabled;
	wire single_run;
	wire auto_reload_enable;
	wire count_clock_source;
	wire [2:0] count_rate_select;

	// Byte address is four times the register index
	function addr_is;
		input [`RET_ADDR_W-1:0] addr;
		input [`RET_ADDR_W-1:0] idx;
		begin
			addr_is = (addr[`RET_ADDR_W-1:2] == idx[`RET_ADDR_W-3:0]) &&
				(addr[1:0] == 2'h0);
		end
	endfunction

	// Tick when low sel+1 bits are all ones: divide by 2^(sel+1)
	function prescale_tick;
		input [`RET_PRESCALE_W-1:0] cnt;
		input [2:0] sel;
		reg [`RET_PRESCALE_W:0] m9;
		begin
			m9 = ({{`RET_PRESCALE_W{1'b0}}, 1'b1} << ({1'b0, sel} + 4'h1)) -
				{{`RET_PRESCALE_W{1'b0}}, 1'b1};
			prescale_tick = ((cnt & m9[`RET_PRESCALE_W-1:0]) ==
				m9[`RET_PRESCALE_W-1:0]);
		end
	endfunction

	assign cfg_sel = addr_is(bus_addr, `RET_CONFIG_IDX);
	assign reload_sel = addr_is(bus_addr, `RET_RELOAD_IDX);
	assign status_sel = addr_is(bus_addr, `RET_STATUS_IDX);

	assign enabled = config_ff[`RET_ENABLE];
	assign single_run = config_ff[`RET_SINGLE_RUN];
	assign auto_reload_enable = config_ff[`RET_AUTO_RELOAD];
	assign count_clock_source = config_ff[`RET_CLK_SRC];
	assign count_rate_select = config_ff[`RET_RATE_HI:`RET_RATE_LO];

	assign stop_hit = (config_ff[`RET_STOP_RX_BEGIN] & rx_begin_evt) |
		(config_ff[`RET_STOP_TX_BEGIN] & tx_begin_evt) |
		(config_ff[`RET_STOP_EXT_ON] & ext_field_on_evt) |
		(config_ff[`RET_STOP_EXT_OFF] & ext_field_off_evt) |
		(config_ff[`RET_STOP_OWN_ON] & own_field_on_evt) |
		(config_ff[`RET_STOP_OWN_OFF] & own_field_off_evt) |
		(config_ff[`RET_STOP_RX_ACT] & rx_activity_evt);

	assign start_hit = (config_ff[`RET_START_RX_BEGIN] & rx_begin_evt) |
		(config_ff[`RET_START_RX_END] & rx_end_evt) |
		(config_ff[`RET_START_TX_BEGIN] & tx_begin_evt) |
		(config_ff[`RET_START_TX_END] & tx_end_evt) |
		(config_ff[`RET_START_EXT_ON] & ext_field_on_evt) |
		(config_ff[`RET_START_EXT_OFF] & ext_field_off_evt) |
		(config_ff[`RET_START_OWN_ON] & own_field_on_evt) |
		(config_ff[`RET_START_OWN_OFF] & own_field_off_evt) |
		imm_start_ff;

	assign tick = count_clock_source ?
		prescale_tick(prescale_ff, count_rate_select) : 1'b1;

	// Config and reload registers
	always @(posedge clock) begin
		if (reset) begin
			config_ff <= `RET_CONFIG_RST;
			reload_ff <= `RET_RELOAD_RST;
			imm_start_ff <= 1'b0;
		end else begin
			// start acts one cycle after write
			imm_start_ff <= bus_write & cfg_sel & bus_wdata[`RET_START_IMM];
			if (bus_write && cfg_sel) begin
				config_ff <= bus_wdata & `RET_CONFIG_WMASK;
			end
			if (bus_write && reload_sel) begin
				reload_ff <= bus_wdata[CNT_W-1:0];
			end
		end
	end

	// Counter control
	always @* begin
		nxt_count = count_ff;
		nxt_running = running_ff;
		nxt_expired = 1'b0;
		nxt_prescale = prescale_ff + {{(`RET_PRESCALE_W-1){1'b0}}, 1'b1};
		if (!enabled) begin
			nxt_running = 1'b0;
			nxt_prescale = {`RET_PRESCALE_W{1'b0}};
		end else if (stop_hit) begin
			nxt_running = 1'b0;
		end else if (start_hit && !(single_run && running_ff)) begin
			nxt_count = reload_ff;
			nxt_running = 1'b1;
			nxt_prescale = {`RET_PRESCALE_W{1'b0}};
		end else if (running_ff && tick) begin
			if (count_ff <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
				nxt_expired = 1'b1;
				if (auto_reload_enable) begin
					nxt_count = reload_ff;
				end else begin
					nxt_count = {CNT_W{1'b0}};
					nxt_running = 1'b0;
				end
			end else begin
				nxt_count = count_ff - {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	always @(posedge clock) begin
		if (reset) begin
			count_ff <= `RET_COUNT_RST;
			running_ff <= 1'b0;
			expired_ff <= 1'b0;
			prescale_ff <= {`RET_PRESCALE_W{1'b0}};
		end else begin
			count_ff <= nxt_count;
			running_ff <= nxt_running;
			expired_ff <= nxt_expired;
			prescale_ff <= nxt_prescale;
		end
	end

	// Read data valid only the cycle after the strobe
	always @* begin
		nxt_rdata = 32'h00000000;
		if (bus_read) begin
			if (cfg_sel) begin
				nxt_rdata = config_ff;
			end else if (reload_sel) begin
				nxt_rdata = {{(32-CNT_W){1'b0}}, reload_ff};
			end else if (status_sel) begin
				nxt_rdata = {{(32-CNT_W){1'b0}}, count_ff};
				nxt_rdata[`RET_STATUS_RUN] = running_ff;
			end else begin
				nxt_rdata = 32'h00000000;
			end
		end
	end

	always @(posedge clock) begin
		if (reset) begin
			rdata_ff <= 32'h00000000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign bus_rdata = rdata_ff;
	assign timer_expired = expired_ff;
	assign timer_running = running_ff;
	assign timer_count = count_ff;

endmodule // ret_event_timer

// ==== design/ret_defines.vh ====
/*
 Register indices, field positions, reset values and widths of the
 event countdown timer.
 Assumes it is included by bare name from the timer module.
*/
`ifndef RET_DEFINES_VH
`define RET_DEFINES_VH

`define RET_ADDR_W 12
`define RET_CONFIG_IDX 12'h03f
`define RET_RELOAD_IDX 12'h040
`define RET_STATUS_IDX 12'h048

`define RET_CONFIG_WMASK 32'h7f03fd7f
`define RET_CONFIG_RST 32'h00000000
`define RET_RELOAD_RST 20'h00000
`define RET_COUNT_RST 20'h00000

`define RET_STOP_RX_BEGIN 30
`define RET_STOP_TX_BEGIN 29
`define RET_STOP_EXT_ON 28
`define RET_STOP_EXT_OFF 27
`define RET_STOP_OWN_ON 26
`define RET_STOP_OWN_OFF 25
`define RET_STOP_RX_ACT 24
`define RET_START_RX_BEGIN 17
`define RET_START_RX_END 16
`define RET_START_TX_BEGIN 15
`define RET_START_TX_END 14
`define RET_START_EXT_ON 13
`define RET_START_EXT_OFF 12
`define RET_START_OWN_ON 11
`define RET_START_OWN_OFF 10
`define RET_START_IMM 8
`define RET_SINGLE_RUN 6
`define RET_RATE_HI 5
`define RET_RATE_LO 3
`define RET_CLK_SRC 2
`define RET_AUTO_RELOAD 1
`define RET_ENABLE 0

`define RET_STATUS_RUN 20
`define RET_PRESCALE_W 8

`endif

// ==== tb/ret_event_timer_checker.sv ====
/* Concurrent checks on the timer outputs.
 Assumes binding to the timer top module. */
`timescale 1ns/1ps
module ret_event_timer_checker #(
	parameter CNT_W = 20
) (
	input wire clock,
	input wire reset,
	input wire bus_read,
	input wire [31:0] bus_rdata,
	input wire timer_expired,
	input wire timer_running,
	input wire [CNT_W-1:0] timer_count
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	AST_EXP_ONE: assert property (timer_expired |=> !timer_expired)
		else $error("expiry pulse too long");
	AST_EXP_ZERO: assert property (timer_expired && !timer_running |-> timer_count == '0)
		else $error("stopped expiry not at zero");
	AST_EXP_RUN: assert property (timer_expired |-> $past(timer_running))
		else $error("expiry while idle");
	AST_EXP_TICK: assert property (timer_expired |-> $past(timer_count) <= 1)
		else $error("expiry before count ran out");
	AST_STOP_HOLD: assert property ($fell(timer_running) && !timer_expired |->
		$stable(timer_count)) else $error("count moved on stop");
	AST_IDLE_HOLD: assert property (!timer_running && !$past(timer_running) |->
		$stable(timer_count)) else $error("count moved while idle");
	AST_DEC_STEP: assert property (timer_running && $past(timer_running) && !timer_expired
		|-> timer_count == $past(timer_count) || timer_count == $past(timer_count) - 1'b1)
		else $error("count step not one");
	AST_RD_IDLE: assert property (!$past(bus_read) |-> bus_rdata == 32'h0)
		else $error("read data outside its cycle");
endmodule // ret_event_timer_checker
bind ret_event_timer ret_event_timer_checker #(.CNT_W(CNT_W)) chk_u (.clock, .reset, .bus_read,
	.bus_rdata, .timer_expired, .timer_running, .timer_count);

// ==== tb/ret_event_source.sv ====
/* Model of the transceiver and field event sources.
 Assumes one request at a time from the bench. */
`timescale 1ns/1ps
module ret_event_source (
	input wire logic clock,
	input wire logic fire,
	input wire logic [3:0] fire_sel,
	output logic [8:0] evt = 9'h000
);
	// Events are single-cycle pulses, never levels
	always_ff @(posedge clock) evt <= fire ? 9'h001 << fire_sel : 9'h000;
endmodule // ret_event_source

// ==== tb/tb.sv ====
/* Bench of the event timer: bus tasks and scenarios.
 Assumes the event model and checker are compiled beside it. */
`timescale 1ns/1ps
`include "ret_defines.vh"
module tb;
	logic clock = 1'b0, reset = 1'b1, bus_write = 1'b0, bus_read = 1'b0, fire = 1'b0;
	logic [11:0] bus_addr = 12'h000;
	logic [31:0] bus_wdata = 32'h0, bus_rdata, d;
	logic [3:0] fire_sel = 4'h0;
	logic [8:0] evt;
	logic timer_expired, timer_running;
	logic [19:0] timer_count;
	int errors = 0, check_count = 0;
	int sbit[8] = '{17, 16, 15, 14, 13, 12, 11, 10};
	int pbit[7] = '{30, 29, 28, 27, 26, 25, 24};
	int pevt[7] = '{0, 2, 4, 5, 6, 7, 8};
	localparam logic [11:0] CFG = 12'h0fc, RLD = 12'h100;
	ret_event_source src_u (.clock, .fire, .fire_sel, .evt);
	ret_event_timer dut_u (.clock, .reset, .bus_addr, .bus_wdata, .bus_write, .bus_read,
		.bus_rdata, .rx_begin_evt(evt[0]), .rx_end_evt(evt[1]), .tx_begin_evt(evt[2]),
		.tx_end_evt(evt[3]), .ext_field_on_evt(evt[4]), .ext_field_off_evt(evt[5]),
		.own_field_on_evt(evt[6]), .own_field_off_evt(evt[7]), .rx_activity_evt(evt[8]),
		.timer_expired, .timer_running, .timer_count);
	initial forever #50 clock = ~clock;
	task automatic give_verdict;
		if (errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		bus_addr <= a;
		bus_wdata <= v;
		bus_write <= 1'b1;
		@(posedge clock);
		bus_write <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [11:0] a);
		bus_addr <= a;
		bus_read <= 1'b1;
		@(posedge clock);
		bus_read <= 1'b0;
		#1 d = bus_rdata;
	endtask
	// Stop first so no restart lands on a running count
	task automatic setup(input logic [31:0] r, input logic [31:0] c);
		wr(CFG, 32'h0);
		wr(RLD, r);
		wr(CFG, c);
	endtask
	task automatic pulse(input int i);
		fire <= 1'b1;
		fire_sel <= 4'(i);
		cyc(1);
		fire <= 1'b0;
		cyc(1);
	endtask
	initial begin
		#5000000;
		errors++;
		give_verdict;
	end
	initial begin
		cyc(20);
		reset <= 1'b0;
		cyc(1);
		rd(RLD);
		chk(d, 32'h0);
		wr(RLD, 32'hffffffff);
		rd(RLD);
		chk(d, 32'h000fffff);
		wr(CFG, 32'hffffffff);
		rd(CFG);
		chk(d, `RET_CONFIG_WMASK);
		cyc(1);
		chk(timer_running, 1'b1);
		rd(12'h104);
		chk(d, 32'h0);
		for (int i = 0; i < 8; i++) begin
			setup(32'h3, 32'h1 | (32'h1 << sbit[i]));
			pulse(i);
			chk({timer_running, timer_count}, {1'b1, 20'h3});
			cyc(3);
			chk({timer_expired, timer_running, timer_count}, {2'b10, 20'h0});
		end
		for (int j = 0; j < 7; j++) begin
			setup(32'h100, 32'h101 | (32'h1 << pbit[j]));
			cyc(2);
			chk(timer_running, 1'b1);
			pulse(pevt[j]);
			chk({timer_running, timer_count}, {1'b0, 20'hfe});
		end
		setup(32'h3, 32'h20000);
		pulse(0);
		chk(timer_running, 1'b0);
		setup(32'h3, 32'h40020001);
		pulse(0);
		chk(timer_running, 1'b0);
		setup(32'h2, 32'h20003);
		pulse(0);
		cyc(2);
		chk({timer_expired, timer_running, timer_count}, {2'b11, 20'h2});
		for (int k = 0; k < 8; k++) begin
			setup(32'h2, 32'h20005 | (k << 3));
			pulse(0);
			cyc((2 << k) - 1);
			chk(timer_count, 20'h2);
			cyc(1);
			chk(timer_count, 20'h1);
		end
		setup(32'h5, 32'h20041);
		pulse(0);
		pulse(0);
		chk(timer_count, 20'h3);
		rd(12'h120);
		chk(d, 32'h00100003);
		give_verdict;
	end
endmodule // tb
